// file: common/cre_pkg.sv
package cre_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // Word offsets of the command area in the shared memory.
  localparam logic [ADDR_W-1:0] OFF_REQ      = 6'h02;
  localparam logic [ADDR_W-1:0] OFF_REC      = 6'h03;
  localparam logic [ADDR_W-1:0] OFF_RES      = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT      = 6'h05;
  localparam logic [ADDR_W-1:0] OFF_WIN      = 6'h06;
  localparam logic [ADDR_W-1:0] OFF_WIN_LAST = 6'h2d;

  // Request codes.
  localparam logic [DATA_W-1:0] REQ_IDLE  = 16'h0000;
  localparam logic [DATA_W-1:0] REQ_STORE = 16'h0001;
  localparam logic [DATA_W-1:0] REQ_READ  = 16'h0002;
  localparam logic [DATA_W-1:0] REQ_ERASE = 16'h0003;

  // Record numbering and size.
  localparam logic [DATA_W-1:0] REC_NONE  = 16'h0000;
  localparam logic [DATA_W-1:0] REC_FIRST = 16'h0bb8;
  localparam logic [DATA_W-1:0] REC_LAST  = 16'h0bd5;
  localparam logic [DATA_W-1:0] REC_BYTES = 16'h0050;
  localparam int unsigned       REC_SLOTS = 30;
  localparam int unsigned       REC_WORDS = 40;

  // Word positions inside one record: 22 connection words, then 18 message words.
  localparam int unsigned W_PAGER    = 0;
  localparam int unsigned W_PREFIX   = 10;
  localparam int unsigned W_LINE     = 11;
  localparam int unsigned W_RSV0_LO  = 12;
  localparam int unsigned W_RSV0_HI  = 21;
  localparam int unsigned W_WAIT     = 22;
  localparam int unsigned W_MSGLEN   = 38;
  localparam int unsigned W_RSV1     = 39;

  // Field limits.
  localparam logic [DATA_W-1:0] PAGER_MAX   = 16'h0003;
  localparam logic [DATA_W-1:0] PAGER_TIMED = 16'h0003;
  localparam logic [DATA_W-1:0] PREFIX_HASH = 16'h000b;
  localparam logic [DATA_W-1:0] PREFIX_NONE = 16'h00ff;
  localparam logic [DATA_W-1:0] LINE_MAX    = 16'h0002;
  localparam logic [DATA_W-1:0] WAIT_MAX    = 16'h00ff;
  localparam logic [DATA_W-1:0] MSGLEN_MAX  = 16'h001e;

  // Result codes; each failure has a code of its own.
  localparam logic [DATA_W-1:0] ERR_OK       = 16'h0000;
  localparam logic [DATA_W-1:0] ERR_BAD_CODE = 16'h7101;
  localparam logic [DATA_W-1:0] ERR_NO_REC   = 16'h7102;
  localparam logic [DATA_W-1:0] ERR_RANGE    = 16'h7103;
  localparam logic [DATA_W-1:0] ERR_COUNT    = 16'h7104;
  localparam logic [DATA_W-1:0] ERR_OCCUPIED = 16'h7105;
  localparam logic [DATA_W-1:0] ERR_EMPTY    = 16'h7106;
  localparam logic [DATA_W-1:0] ERR_FIELD    = 16'h7107;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cre_host_req_t;

  typedef enum logic [1:0] {
    CRE_IDLE  = 2'b00,
    CRE_CHECK = 2'b01,
    CRE_XFER  = 2'b11,
    CRE_DONE  = 2'b10
  } cre_state_t;

endpackage

// file: verilog/cre_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cre_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else if (ce) begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// file: verilog/cre_record_store.sv
`timescale 1ns/1ps
`default_nettype none
module cre_record_store #(
  parameter int unsigned WORDS = 40,
  parameter int unsigned SLOTS = 30,
  parameter int unsigned W     = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire logic [$clog2(SLOTS)-1:0] slot,
  input  wire logic [$clog2(WORDS)-1:0] word,
  input  wire logic                     wr_en,
  input  wire logic [W-1:0]             wdata,
  output logic      [W-1:0]             rdata,
  input  wire logic                     set_valid,
  input  wire logic                     clr_valid,
  output logic      [SLOTS-1:0]         valid
);
  // Record contents keep no reset; only the occupancy flags are cleared.
  logic [W-1:0]     mem [SLOTS][WORDS];
  logic [SLOTS-1:0] valid_r;

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[slot][word] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_r <= '0;
    end else if (ce) begin
      if (set_valid) begin
        valid_r[slot] <= 1'b1;
      end else if (clr_valid) begin
        valid_r[slot] <= 1'b0;
      end
    end
  end

  assign rdata = mem[slot][word];
  assign valid = valid_r;
endmodule
`default_nettype wire

// file: verilog/cre_access.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - request word: zero idle, two read
// - code one stores, three erases record
// - record number zero means none selected
// - result zero on success, nonzero failure
// - failure result is a specific error code
// - read copies record into data words
// - transfers use read/write handshake line pairs
// - connection part 44 bytes, reserved zero
// - pager type zero none, one-three classes
// - prefix digits, 10 star, 11 hash, 255
// - line type pulse, tone, ISDN
// - message part 36 bytes, reserved zero
// - wait time 0..255 seconds
// - wait time only used for pager three
// - message length zero or 1..30
module cre_access #(
  parameter int unsigned REC_WORDS = cre_pkg::REC_WORDS,
  parameter int unsigned SLOTS     = cre_pkg::REC_SLOTS
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire cre_pkg::cre_host_req_t        host_req,
  output logic      [cre_pkg::DATA_W-1:0]    host_rdata,
  input  wire logic                          nv_write_request_line,
  output logic                               nv_write_complete_line,
  input  wire logic                          nv_read_request_line,
  output logic                               nv_read_complete_line,
  output logic                               module_ready_line,
  output logic                               watchdog_fault_line
);
  localparam int unsigned IDX_W  = $clog2(REC_WORDS);
  localparam int unsigned SLOT_W = $clog2(SLOTS);
  localparam int unsigned DW     = cre_pkg::DATA_W;

  logic [1:0]             req_s;
  cre_pkg::cre_state_t    state_r;
  logic [IDX_W-1:0]       idx_r, win_idx;
  logic [DW-1:0]          code_r, recno_r, result_r, count_r, rdata_r, mem_rdata, check_err;
  logic [DW-1:0]          win_r [REC_WORDS];
  logic [SLOTS-1:0]       valid;
  logic [SLOT_W-1:0]      slot;
  logic                   wreq_s, rreq_s, own_req, op_read_r, wdone_r, rdone_r, ready_r, fault_r;
  logic                   in_win, in_range, field_ok, finish_now, xfer_last, mem_wr, set_valid, clr_valid;
  // Handshake lines come from the host's clock world, so both pass two flops.
  cre_sync #(
    .W (2)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({nv_read_request_line, nv_write_request_line}),
    .q    (req_s)
  );
  assign wreq_s = req_s[0];
  assign rreq_s = req_s[1];

  assign slot     = SLOT_W'(recno_r - cre_pkg::REC_FIRST);
  assign in_range = (recno_r >= cre_pkg::REC_FIRST) && (recno_r <= cre_pkg::REC_LAST);
  assign win_idx  = IDX_W'(host_req.addr - cre_pkg::OFF_WIN);
  assign in_win   = (host_req.addr >= cre_pkg::OFF_WIN) && (host_req.addr <= cre_pkg::OFF_WIN_LAST);
  assign own_req  = op_read_r ? rreq_s : wreq_s;
  assign xfer_last = (state_r == cre_pkg::CRE_XFER) && (idx_r == IDX_W'(REC_WORDS - 1));
  // Field checks run on the window before anything is committed to the store.
  always_comb begin
    field_ok = (win_r[cre_pkg::W_PAGER] <= cre_pkg::PAGER_MAX);
    if (win_r[cre_pkg::W_PREFIX] > cre_pkg::PREFIX_HASH &&
        win_r[cre_pkg::W_PREFIX] != cre_pkg::PREFIX_NONE) begin
      field_ok = 1'b0;
    end
    if (win_r[cre_pkg::W_LINE] > cre_pkg::LINE_MAX) begin
      field_ok = 1'b0;
    end
    // An oversized wait time is harmless when the pager type never uses it.
    if (win_r[cre_pkg::W_PAGER] == cre_pkg::PAGER_TIMED &&
        win_r[cre_pkg::W_WAIT] > cre_pkg::WAIT_MAX) begin
      field_ok = 1'b0;
    end
    if (win_r[cre_pkg::W_MSGLEN] > cre_pkg::MSGLEN_MAX) begin
      field_ok = 1'b0;
    end
    for (int i = cre_pkg::W_RSV0_LO; i <= cre_pkg::W_RSV0_HI; i++) begin
      if (win_r[i] != '0) begin
        field_ok = 1'b0;
      end
    end
    if (win_r[cre_pkg::W_RSV1] != '0) begin
      field_ok = 1'b0;
    end
  end
  // First failing check decides the code reported back.
  always_comb begin
    check_err = cre_pkg::ERR_OK;
    if (op_read_r ? (code_r != cre_pkg::REQ_READ)
                  : (code_r != cre_pkg::REQ_STORE && code_r != cre_pkg::REQ_ERASE)) begin
      check_err = cre_pkg::ERR_BAD_CODE;
    end else if (recno_r == cre_pkg::REC_NONE) begin
      check_err = cre_pkg::ERR_NO_REC;
    end else if (!in_range) begin
      check_err = cre_pkg::ERR_RANGE;
    end else if (code_r == cre_pkg::REQ_STORE && count_r != cre_pkg::REC_BYTES) begin
      check_err = cre_pkg::ERR_COUNT;
    end else if (code_r == cre_pkg::REQ_STORE && valid[slot]) begin
      check_err = cre_pkg::ERR_OCCUPIED;
    end else if (code_r != cre_pkg::REQ_STORE && !valid[slot]) begin
      check_err = cre_pkg::ERR_EMPTY;
    end else if (code_r == cre_pkg::REQ_STORE && !field_ok) begin
      check_err = cre_pkg::ERR_FIELD;
    end
  end
  // Erase and every refused request finish straight from the check state.
  assign finish_now = (state_r == cre_pkg::CRE_CHECK) &&
                      (check_err != cre_pkg::ERR_OK || code_r == cre_pkg::REQ_ERASE);
  assign mem_wr    = (state_r == cre_pkg::CRE_XFER) && !op_read_r;
  assign set_valid = xfer_last && !op_read_r;
  assign clr_valid = (state_r == cre_pkg::CRE_CHECK) && (check_err == cre_pkg::ERR_OK) &&
                     (code_r == cre_pkg::REQ_ERASE);

  cre_record_store #(
    .WORDS (REC_WORDS),
    .SLOTS (SLOTS),
    .W     (DW)
  ) u_store (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .slot      (slot),
    .word      (idx_r),
    .wr_en     (mem_wr),
    .wdata     (win_r[idx_r]),
    .rdata     (mem_rdata),
    .set_valid (set_valid),
    .clr_valid (clr_valid),
    .valid     (valid)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= cre_pkg::CRE_IDLE;
      op_read_r <= 1'b0;
      idx_r     <= '0;
    end else if (ce) begin
      unique case (state_r)
        cre_pkg::CRE_IDLE: begin
          if (wreq_s || rreq_s) begin
            op_read_r <= rreq_s;
            state_r   <= cre_pkg::CRE_CHECK;
          end
        end
        cre_pkg::CRE_CHECK: begin
          idx_r   <= '0;
          state_r <= finish_now ? cre_pkg::CRE_DONE : cre_pkg::CRE_XFER;
        end
        cre_pkg::CRE_XFER: begin
          idx_r <= IDX_W'(idx_r + 1'b1);
          if (xfer_last) begin
            state_r <= cre_pkg::CRE_DONE;
          end
        end
        cre_pkg::CRE_DONE: begin
          if (!own_req) begin
            state_r <= cre_pkg::CRE_IDLE;
          end
        end
      endcase
    end
  end
  // Result word and completion lines.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= cre_pkg::ERR_OK;
      wdone_r  <= 1'b0;
      rdone_r  <= 1'b0;
    end else if (ce) begin
      if (finish_now || xfer_last) begin
        result_r <= finish_now ? check_err : cre_pkg::ERR_OK;
        wdone_r  <= !op_read_r;
        rdone_r  <= op_read_r;
      end else if (state_r == cre_pkg::CRE_DONE && !own_req) begin
        wdone_r <= 1'b0;
        rdone_r <= 1'b0;
      end
    end
  end
  // Host-writable command words; the result word ignores host writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_r  <= cre_pkg::REQ_IDLE;
      recno_r <= cre_pkg::REC_NONE;
      count_r <= '0;
    end else if (ce && host_req.wr) begin
      case (host_req.addr)
        cre_pkg::OFF_REQ: code_r  <= host_req.wdata;
        cre_pkg::OFF_REC: recno_r <= host_req.wdata;
        cre_pkg::OFF_CNT: count_r <= host_req.wdata;
        default: ;
      endcase
    end
  end
  // The record copy takes precedence over a host write into the same window.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < REC_WORDS; i++) begin
        win_r[i] <= '0;
      end
    end else if (ce) begin
      if (state_r == cre_pkg::CRE_XFER && op_read_r) begin
        win_r[idx_r] <= mem_rdata;
      end else if (host_req.wr && in_win) begin
        win_r[win_idx] <= host_req.wdata;
      end
    end
  end
  // Host read port, one cycle of latency; unmapped words read as zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (ce && host_req.rd) begin
      if (host_req.addr == cre_pkg::OFF_REQ) begin
        rdata_r <= code_r;
      end else if (host_req.addr == cre_pkg::OFF_REC) begin
        rdata_r <= recno_r;
      end else if (host_req.addr == cre_pkg::OFF_RES) begin
        rdata_r <= result_r;
      end else if (host_req.addr == cre_pkg::OFF_CNT) begin
        rdata_r <= count_r;
      end else if (in_win) begin
        rdata_r <= win_r[win_idx];
      end else begin
        rdata_r <= '0;
      end
    end
  end
  // No watchdog lives here, so the fault line simply stays low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (ce) begin
      ready_r <= 1'b1;
      fault_r <= 1'b0;
    end
  end

  assign host_rdata             = rdata_r;
  assign nv_write_complete_line = wdone_r;
  assign nv_read_complete_line  = rdone_r;
  assign module_ready_line      = ready_r;
  assign watchdog_fault_line    = fault_r;

  property p_read_on_write_line;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_CHECK && ce && !op_read_r && code_r == cre_pkg::REQ_READ)
      |=> (result_r == cre_pkg::ERR_BAD_CODE && nv_write_complete_line);
  endproperty
  a_read_on_write_line: assert property (p_read_on_write_line) else $error("read code on write line accepted");
  property p_code_out;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_CHECK && ce && code_r > cre_pkg::REQ_ERASE)
      |=> (result_r == cre_pkg::ERR_BAD_CODE && state_r == cre_pkg::CRE_DONE);
  endproperty
  a_code_out: assert property (p_code_out) else $error("undefined request code not refused");
  property p_no_record;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_CHECK && ce && !op_read_r && recno_r == cre_pkg::REC_NONE &&
       (code_r == cre_pkg::REQ_STORE || code_r == cre_pkg::REQ_ERASE))
      |=> (result_r == cre_pkg::ERR_NO_REC);
  endproperty
  a_no_record: assert property (p_no_record) else $error("zero record number not refused");
  property p_count;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_CHECK && ce && !op_read_r && code_r == cre_pkg::REQ_STORE &&
       in_range && count_r != cre_pkg::REC_BYTES)
      |=> (result_r == cre_pkg::ERR_COUNT);
  endproperty
  a_count: assert property (p_count) else $error("wrong byte count not refused");
  property p_ok_result;
    @(posedge clk) disable iff (!rstn)
      (xfer_last && ce)
      |=> (result_r == cre_pkg::ERR_OK && state_r == cre_pkg::CRE_DONE &&
           (nv_write_complete_line || nv_read_complete_line));
  endproperty
  a_ok_result: assert property (p_ok_result) else $error("transfer end without zero result");
  property p_read_copy;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_XFER && ce && op_read_r)
      |=> (win_r[$past(idx_r)] == $past(mem_rdata));
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("record word not copied to window");
  property p_erase;
    @(posedge clk) disable iff (!rstn)
      (clr_valid && ce)
      |=> (!valid[$past(slot)] && nv_write_complete_line && result_r == cre_pkg::ERR_OK);
  endproperty
  a_erase: assert property (p_erase) else $error("erase left record occupied");
  property p_complete_hold;
    @(posedge clk) disable iff (!rstn)
      (nv_write_complete_line && wreq_s) |=> nv_write_complete_line;
  endproperty
  a_complete_hold: assert property (p_complete_hold) else $error("write complete dropped early");
  property p_release;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_DONE && ce && !op_read_r && !wreq_s)
      |=> (!nv_write_complete_line && state_r == cre_pkg::CRE_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("write complete kept after release");
  property p_read_pair;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_IDLE && ce && rreq_s)
      |=> (state_r == cre_pkg::CRE_CHECK && op_read_r) ##1 (!nv_write_complete_line);
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("read request not on read pair");
  property p_bad_pager;
    @(posedge clk) disable iff (!rstn)
      (state_r == cre_pkg::CRE_CHECK && ce && !op_read_r && code_r == cre_pkg::REQ_STORE &&
       in_range && count_r == cre_pkg::REC_BYTES && !valid[slot] &&
       win_r[cre_pkg::W_PAGER] > cre_pkg::PAGER_MAX)
      |=> (result_r == cre_pkg::ERR_FIELD);
  endproperty
  a_bad_pager: assert property (p_bad_pager) else $error("bad pager type stored");
endmodule
`default_nettype wire

// file: bench/cre_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cre_host_model (
  input  wire logic                       clk,
  input  wire logic [cre_pkg::DATA_W-1:0] host_rdata,
  input  wire logic                       wr_done,
  input  wire logic                       rd_done,
  output var  cre_pkg::cre_host_req_t     host_req,
  output logic                            wr_line,
  output logic                            rd_line
);
  initial begin
    host_req = '0;
    wr_line  = 1'b0;
    rd_line  = 1'b0;
  end

  // An idle bus shows the inverse of the last value, so a stale address or data word cannot pass by luck.
  task automatic put(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    host_req.wr    = 1'b1;
    host_req.addr  = a;
    host_req.wdata = d;
    @(negedge clk);
    host_req.wr    = 1'b0;
    host_req.addr  = ~a;
    host_req.wdata = ~d;
  endtask

  task automatic get(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk);
    host_req.rd   = 1'b1;
    host_req.addr = a;
    @(negedge clk);
    host_req.rd   = 1'b0;
    host_req.addr = ~a;
    d             = host_rdata;
  endtask

  // Raise the chosen request line, hold it until its complete line is seen, read the result, then release.
  task automatic request(input bit rp, output logic [15:0] res, output bit hung);
    int n;
    hung = 1'b0;
    @(negedge clk);
    if (rp) rd_line = 1'b1;
    else wr_line = 1'b1;
    n = 0;
    while (((rp ? rd_done : wr_done) !== 1'b1) && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) hung = 1'b1;
    get(cre_pkg::OFF_RES, res);
    rd_line = 1'b0;
    wr_line = 1'b0;
    n = 0;
    while ((wr_done | rd_done) !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) hung = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] OK  = cre_pkg::ERR_OK;
  localparam logic [15:0] FLD = cre_pkg::ERR_FIELD;
  localparam logic [15:0] ST  = cre_pkg::REQ_STORE;
  localparam logic [15:0] ER  = cre_pkg::REQ_ERASE;
  localparam logic [15:0] RD  = cre_pkg::REQ_READ;
  localparam logic [15:0] R0  = cre_pkg::REC_FIRST;
  logic                       clk  = 1'b0;
  logic                       rstn = 1'b0;
  cre_pkg::cre_host_req_t     host_req;
  logic [cre_pkg::DATA_W-1:0] host_rdata;
  logic                       wr_line;
  logic                       wr_done;
  logic                       rd_line;
  logic                       rd_done;
  logic                       ready;
  logic                       wdog;
  int                         n_fail = 0;
  int                         checks = 0;
  logic [15:0]                tmpl [40];
  logic [15:0]                rec [40];
  logic [15:0]                cnt;

  always #4 clk = ~clk;

  cre_access u_cre_access (.clk(clk), .rstn(rstn), .ce(1'b1), .host_req(host_req), .host_rdata(host_rdata),
    .nv_write_request_line(wr_line), .nv_write_complete_line(wr_done), .nv_read_request_line(rd_line),
    .nv_read_complete_line(rd_done), .module_ready_line(ready), .watchdog_fault_line(wdog));
  cre_host_model u_cre_host_model (.clk(clk), .host_rdata(host_rdata), .wr_done(wr_done), .rd_done(rd_done),
    .host_req(host_req), .wr_line(wr_line), .rd_line(rd_line));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic op(input logic [15:0] code, input logic [15:0] num, input bit rp, input logic [15:0] exp);
    logic [15:0] res;
    bit          hung;
    u_cre_host_model.put(cre_pkg::OFF_REQ, code);
    u_cre_host_model.put(cre_pkg::OFF_REC, num);
    u_cre_host_model.put(cre_pkg::OFF_CNT, cnt);
    if (code === ST)
      for (int k = 0; k < 40; k++) u_cre_host_model.put(cre_pkg::OFF_WIN + 6'(k), rec[k]);
    u_cre_host_model.request(rp, res, hung);
    if (hung) begin
      n_fail++;
      $display("ERROR at %0t: handshake did not finish", $time);
      end_of_test();
    end
    chk(res, exp, "result word");
  endtask

  task automatic t_reset;
    logic [15:0] d;
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    chk({14'h0, ready, wdog}, 16'h0000, "status in reset");
    chk({14'h0, wr_done, rd_done}, 16'h0000, "complete in reset");
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk({14'h0, ready, wdog}, 16'h0002, "status after reset");
    for (int a = 2; a < 7; a++) begin
      u_cre_host_model.get(6'(a), d);
      chk(d, 16'h0000, "register reset value");
    end
    $display("test reset done");
  endtask

  task automatic t_store_read;
    logic [15:0] d;
    rec = tmpl;
    op(ST, R0, 1'b0, OK);
    op(ST, R0, 1'b0, cre_pkg::ERR_OCCUPIED);
    for (int k = 0; k < 40; k++) u_cre_host_model.put(cre_pkg::OFF_WIN + 6'(k), ~tmpl[k]);
    op(RD, R0, 1'b1, OK);
    for (int k = 0; k < 40; k++) begin
      u_cre_host_model.get(cre_pkg::OFF_WIN + 6'(k), d);
      chk(d, tmpl[k], "read back word");
    end
    op(ER, R0, 1'b0, OK);
    op(RD, R0, 1'b1, cre_pkg::ERR_EMPTY);
    op(ER, R0, 1'b0, cre_pkg::ERR_EMPTY);
    $display("test store read erase done");
  endtask

  task automatic t_codes;
    rec = tmpl;
    op(cre_pkg::REQ_IDLE, R0, 1'b0, cre_pkg::ERR_BAD_CODE);
    op(RD, R0, 1'b0, cre_pkg::ERR_BAD_CODE);
    op(ST, R0, 1'b1, cre_pkg::ERR_BAD_CODE);
    op(ER, R0, 1'b1, cre_pkg::ERR_BAD_CODE);
    op(16'h0004, R0, 1'b0, cre_pkg::ERR_BAD_CODE);
    op(ST, cre_pkg::REC_NONE, 1'b0, cre_pkg::ERR_NO_REC);
    op(ER, cre_pkg::REC_NONE, 1'b0, cre_pkg::ERR_NO_REC);
    op(ST, 16'h0bb7, 1'b0, cre_pkg::ERR_RANGE);
    op(ST, 16'h0bd6, 1'b0, cre_pkg::ERR_RANGE);
    cnt = 16'h004f;
    op(ST, cre_pkg::REC_LAST, 1'b0, cre_pkg::ERR_COUNT);
    cnt = cre_pkg::REC_BYTES;
    op(ST, cre_pkg::REC_LAST, 1'b0, OK);
    op(ER, cre_pkg::REC_LAST, 1'b0, OK);
    $display("test codes done");
  endtask

  // The second change defaults to the wait word at its template value, so one-field cases stay short.
  task automatic fld(input int w1, input logic [15:0] v1, input logic [15:0] exp,
                     input int w2 = cre_pkg::W_WAIT, input logic [15:0] v2 = 16'h0000);
    rec     = tmpl;
    rec[w1] = v1;
    rec[w2] = v2;
    op(ST, 16'h0bb9, 1'b0, exp);
    if (exp === OK) op(ER, 16'h0bb9, 1'b0, OK);
  endtask

  task automatic t_fields;
    fld(cre_pkg::W_PAGER, 16'h0004, FLD);
    fld(cre_pkg::W_PAGER, 16'h0000, OK);
    fld(cre_pkg::W_PREFIX, 16'h000a, OK);
    fld(cre_pkg::W_PREFIX, 16'h000b, OK);
    fld(cre_pkg::W_PREFIX, 16'h000c, FLD);
    fld(cre_pkg::W_LINE, 16'h0002, OK);
    fld(cre_pkg::W_LINE, 16'h0003, FLD);
    fld(cre_pkg::W_RSV0_LO, 16'h0001, FLD);
    fld(cre_pkg::W_RSV0_HI, 16'h8000, FLD);
    fld(cre_pkg::W_RSV1, 16'h0001, FLD);
    fld(cre_pkg::W_MSGLEN, 16'h001e, OK);
    fld(cre_pkg::W_MSGLEN, 16'h001f, FLD);
    fld(cre_pkg::W_PAGER, 16'h0003, OK, cre_pkg::W_WAIT, 16'h00ff);
    fld(cre_pkg::W_PAGER, 16'h0003, FLD, cre_pkg::W_WAIT, 16'h0100);
    fld(cre_pkg::W_PAGER, 16'h0002, OK, cre_pkg::W_WAIT, 16'h0100);
    $display("test fields done");
  endtask

  task automatic t_map;
    logic [15:0] d;
    logic [5:0]  un [4] = '{6'h00, 6'h01, 6'h2e, 6'h3f};
    for (int i = 0; i < 4; i++) begin
      u_cre_host_model.put(un[i], 16'h5a5a);
      u_cre_host_model.get(un[i], d);
      chk(d, 16'h0000, "unmapped read");
    end
    u_cre_host_model.put(cre_pkg::OFF_RES, 16'h1234);
    u_cre_host_model.get(cre_pkg::OFF_RES, d);
    chk(d, OK, "result word is read only");
    u_cre_host_model.put(cre_pkg::OFF_WIN_LAST, 16'hc3c3);
    u_cre_host_model.get(cre_pkg::OFF_WIN_LAST, d);
    chk(d, 16'hc3c3, "last window word");
    $display("test map done");
  endtask

  initial begin
    cnt = cre_pkg::REC_BYTES;
    for (int k = 0; k < 40; k++) tmpl[k] = (k >= 1 && k <= 9) ? 16'h2020 : 16'h0000;
    tmpl[0]  = 16'h0001;
    tmpl[1]  = 16'h3035;
    tmpl[10] = cre_pkg::PREFIX_NONE;
    tmpl[11] = 16'h0001;
    tmpl[23] = 16'h6948;
    tmpl[38] = 16'h0002;
    t_reset();
    t_store_read();
    t_codes();
    t_fields();
    t_map();
    end_of_test();
  end
endmodule
`default_nettype wire
